// >>> rtl/bme_exec.sv
// Behaviour
// - opcode 57 selector 0 inverts one bit
// - complement sets Z on zero, clears S
// - opcode 77 selector 0 clears bit, no flags
// - opcode 77 selector 1 sets bit, no flags
// - second byte: register nibble, bit index, selector
// - opcode 07 ORs bit 0 with bit b
// - bit OR changes only the destination bit
// - bit OR sets Z when the destination bit is zero, clears S
// - bit OR is three bytes, six cycles
// - flags live at register address D5
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module bme_exec
    import bme_pkg::*;
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // core status
    output logic execBusy
);

    typedef struct packed {
        logic [255:0][7:0] regs;
        logic [7:0] wrkBase;
        logic [7:0] opc;
        logic [7:0] b2;
        logic [7:0] b3;
        logic busy;
        logic illegal;
        logic [2:0] cnt;
        logic pendW;
        logic pendOk;
        logic [9:0] pendIdx;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } bme_state_t;

    localparam bme_state_t RST_STATE = '{
        regs: {256{REGS_RST}},
        wrkBase: WBASE_RST,
        opc: 8'h00,
        b2: 8'h00,
        b3: 8'h00,
        busy: 1'b0,
        illegal: 1'b0,
        cnt: 3'h0,
        pendW: 1'b0,
        pendOk: 1'b0,
        pendIdx: 10'h000,
        hreadyout: 1'b1,
        hresp: 1'b0,
        hrdata: 32'h0000_0000
    };

    bme_state_t s_r;
    bme_state_t s_nxt;

    // working register address from the base and a nibble
    function automatic logic [7:0] wrkAddr(input logic [7:0] base, input logic [3:0] nib);
        wrkAddr = {base[7:4], nib};
    endfunction

    function automatic logic [31:0] rdWord(input bme_state_t st, input logic [31:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        rdWord = 32'h0000_0000;
        if (addr[31:12] == 20'h00000) begin
            if (idx[9:8] == IDX_REGSPACE) begin
                rdWord = {24'h000000, st.regs[idx[7:0]]};
            end else if (idx == IDX_INSTR) begin
                rdWord = {8'h00, st.b3, st.b2, st.opc};
            end else if (idx == IDX_WBASE) begin
                rdWord = {24'h000000, st.wrkBase};
            end else if (idx == IDX_STATUS) begin
                rdWord[STAT_BUSY] = st.busy;
                rdWord[STAT_ILLEGAL] = st.illegal;
            end
        end
    endfunction

    // operand selection
    logic [7:0] rnAddr;
    logic [7:0] dstAddr;
    logic [7:0] srcAddr;
    logic orToFar;

    bme_alu_if aluBus();

    bme_bit_alu u_alu (
        .bus(aluBus.alu)
    );

    assign rnAddr = wrkAddr(s_r.wrkBase, s_r.b2[B2_REG_HI:B2_REG_LO]);
    assign orToFar = (s_r.opc == OPC_BIT_OR) && s_r.b2[B2_SEL];
    assign dstAddr = orToFar ? s_r.b3 : rnAddr;
    assign srcAddr = orToFar ? rnAddr : s_r.b3;
    assign aluBus.opc = s_r.opc;
    assign aluBus.sel = s_r.b2[B2_SEL];
    assign aluBus.bitIdx = s_r.b2[B2_BIT_HI:B2_BIT_LO];
    assign aluBus.dstVal = s_r.regs[dstAddr];
    assign aluBus.srcVal = s_r.regs[srcAddr];

    always_comb begin
        s_nxt = s_r;
        s_nxt.hresp = 1'b0;

        // execution countdown and write-back
        if (s_r.busy) begin
            if (s_r.cnt != 3'h0) begin
                s_nxt.cnt = s_r.cnt - 3'h1;
            end else begin
                s_nxt.regs[dstAddr] = aluBus.result;
                if (aluBus.flagUpd) begin
                    // only Z and S change; C, V, D, H hold
                    s_nxt.regs[REG_FLAG_ADDR][FLAG_Z] = aluBus.zero;
                    s_nxt.regs[REG_FLAG_ADDR][FLAG_S] = 1'b0;
                end
                s_nxt.busy = 1'b0;
            end
        end

        // write data phase, stalled while an instruction runs
        if (s_r.pendW && !s_r.busy) begin
            s_nxt.pendW = 1'b0;
            s_nxt.hreadyout = 1'b1;
            if (s_r.pendOk) begin
                if (s_r.pendIdx[9:8] == IDX_REGSPACE) begin
                    s_nxt.regs[s_r.pendIdx[7:0]] = hwdata[7:0];
                end else if (s_r.pendIdx == IDX_WBASE) begin
                    s_nxt.wrkBase = hwdata[7:0];
                end else if (s_r.pendIdx == IDX_INSTR) begin
                    s_nxt.opc = hwdata[INS_OPC_LO +: 8];
                    s_nxt.b2 = hwdata[INS_B2_LO +: 8];
                    s_nxt.b3 = hwdata[INS_B3_LO +: 8];
                    if (isLegal(hwdata[INS_OPC_LO +: 8], hwdata[INS_B2_LO +: 8])) begin
                        s_nxt.busy = 1'b1;
                        s_nxt.illegal = 1'b0;
                        if (hwdata[INS_OPC_LO +: 8] == OPC_BIT_OR) begin
                            s_nxt.cnt = CNT_BIT_OR;
                        end else begin
                            s_nxt.cnt = CNT_TWO_BYTE;
                        end
                    end else begin
                        s_nxt.illegal = 1'b1;
                    end
                end
            end
        end

        // address phase
        if (hsel && htrans[1] && hready) begin
            if (hwrite) begin
                s_nxt.pendW = 1'b1;
                s_nxt.pendIdx = haddr[11:2];
                s_nxt.pendOk = (haddr[31:12] == 20'h00000);
                s_nxt.hreadyout = !s_nxt.busy;
            end else begin
                s_nxt.hrdata = rdWord(s_nxt, haddr);
                s_nxt.hreadyout = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= RST_STATE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign hreadyout = s_r.hreadyout;
    assign hresp = s_r.hresp;
    assign hrdata = s_r.hrdata;
    assign execBusy = s_r.busy;

endmodule

// >>> rtl/bme_pkg.sv
package bme_pkg;

    // opcodes
    localparam logic [7:0] OPC_BIT_COMPLEMENT = 8'h57;
    localparam logic [7:0] OPC_BIT_CLR_SET = 8'h77;
    localparam logic [7:0] OPC_BIT_OR = 8'h07;

    // instruction lengths in bytes and cycles
    localparam int LEN_TWO_BYTE = 2;
    localparam int LEN_BIT_OR = 3;
    localparam int CYC_TWO_BYTE = 4;
    localparam int CYC_BIT_OR = 6;
    localparam logic [2:0] CNT_TWO_BYTE = 3'(CYC_TWO_BYTE - 1);
    localparam logic [2:0] CNT_BIT_OR = 3'(CYC_BIT_OR - 1);

    // second byte fields
    localparam int B2_REG_HI = 7;
    localparam int B2_REG_LO = 4;
    localparam int B2_BIT_HI = 3;
    localparam int B2_BIT_LO = 1;
    localparam int B2_SEL = 0;

    // condition flag register and its bits
    localparam logic [7:0] REG_FLAG_ADDR = 8'hD5;
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;

    // bus word indices (byte address = 4 * index)
    localparam logic [9:0] IDX_INSTR = 10'h100;
    localparam logic [9:0] IDX_WBASE = 10'h101;
    localparam logic [9:0] IDX_STATUS = 10'h102;
    localparam logic [1:0] IDX_REGSPACE = 2'h0;

    // instruction word layout
    localparam int INS_OPC_LO = 0;
    localparam int INS_B2_LO = 8;
    localparam int INS_B3_LO = 16;

    // status bits
    localparam int STAT_BUSY = 0;
    localparam int STAT_ILLEGAL = 1;

    // reset values
    localparam logic [7:0] REGS_RST = 8'h00;
    localparam logic [7:0] WBASE_RST = 8'hC0;

    function automatic logic [7:0] bitMask(input logic [2:0] idx);
        bitMask = 8'(8'h01 << idx);
    endfunction

    function automatic logic isLegal(input logic [7:0] opc, input logic [7:0] b2);
        isLegal = (opc == OPC_BIT_COMPLEMENT && !b2[B2_SEL]) ||
                  (opc == OPC_BIT_CLR_SET) || (opc == OPC_BIT_OR);
    endfunction

endpackage

// >>> rtl/bme_alu_if.sv
`timescale 1ns/1ps
interface bme_alu_if;
    logic [7:0] opc;
    logic sel;
    logic [2:0] bitIdx;
    logic [7:0] dstVal;
    logic [7:0] srcVal;
    logic [7:0] result;
    logic zero;
    logic flagUpd;

    modport exec (output opc, output sel, output bitIdx, output dstVal, output srcVal,
                  input result, input zero, input flagUpd);
    modport alu (input opc, input sel, input bitIdx, input dstVal, input srcVal,
                 output result, output zero, output flagUpd);
endinterface

// >>> rtl/bme_bit_alu.sv
`timescale 1ns/1ps
module bme_bit_alu
    import bme_pkg::*;
(
    // operands and result
    bme_alu_if.alu bus
);

    logic [7:0] mask;

    always_comb begin
        mask = bitMask(bus.bitIdx);
        bus.result = bus.dstVal;
        bus.zero = 1'b0;
        bus.flagUpd = 1'b0;
        unique case (bus.opc)
            OPC_BIT_COMPLEMENT: begin
                bus.result = bus.dstVal ^ mask;
                bus.zero = (bus.result == 8'h00);
                bus.flagUpd = 1'b1;
            end
            OPC_BIT_CLR_SET: begin
                if (bus.sel) begin
                    bus.result = bus.dstVal | mask;
                end else begin
                    bus.result = bus.dstVal & ~mask;
                end
            end
            OPC_BIT_OR: begin
                if (bus.sel) begin
                    bus.result = bus.dstVal | (bus.srcVal[0] ? mask : 8'h00);
                    bus.zero = ~bus.result[bus.bitIdx];
                end else begin
                    bus.result = {bus.dstVal[7:1], bus.dstVal[0] | bus.srcVal[bus.bitIdx]};
                    bus.zero = ~bus.result[0];
                end
                bus.flagUpd = 1'b1;
            end
            default: begin
                bus.result = bus.dstVal;
            end
        endcase
    end

endmodule

// >>> tb/bme_exec_sva.sv
`timescale 1ns/1ps
module bme_exec_sva
    import bme_pkg::*;
(
    // clock, reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // status
    input wire logic execBusy
);
    logic wrI_r, wrA_r, go, twoB, orB, badB;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrI_r <= 1'b0;
            wrA_r <= 1'b0;
        end else if (ce && hready) begin
            wrI_r <= hsel && htrans[1] && hwrite && haddr == 32'h0000_0400;
            wrA_r <= hsel && htrans[1] && hwrite;
        end
    end
    assign go = wrI_r && hreadyout && !execBusy;
    assign twoB = hwdata[7:0] == OPC_BIT_CLR_SET || hwdata[7:0] == OPC_BIT_COMPLEMENT && !hwdata[8];
    assign orB = hwdata[7:0] == OPC_BIT_OR;
    assign badB = hwdata[7:0] == OPC_BIT_COMPLEMENT && hwdata[8];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n || !ce);
    a_two_byte: assert property (
        go && twoB |=> execBusy [*4] ##1 !execBusy) else $error("short busy wrong");
    a_or_len: assert property (
        go && orB |=> execBusy [*6] ##1 !execBusy) else $error("bit or busy wrong");
    a_bad_idle: assert property (
        go && badB |=> !execBusy [*2]) else $error("illegal code ran");
    a_busy_cause: assert property (
        $rose(execBusy) |-> $past(wrI_r)) else $error("busy without write");
    a_busy_max: assert property (
        execBusy [*6] |=> !execBusy) else $error("busy too long");
    a_stall_write: assert property (
        wrA_r && execBusy && $past(execBusy) |-> !hreadyout) else $error("no stall");
    a_idle_ready: assert property (
        !wrA_r |-> hreadyout) else $error("ready low");
    a_resp_okay: assert property (
        !hresp) else $error("error response");
    c_bor: cover property (go && orB);
    c_stall: cover property (wrA_r && !hreadyout);
    c_bad: cover property (go && badB);
endmodule
bind bme_exec bme_exec_sva u_sva (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .execBusy(execBusy));

// >>> tb/bit_manipulation_exec_bench.sv
`timescale 1ns/1ps
module bit_manipulation_exec_bench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b1;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, execBusy;
    logic [31:0] hrdata, rd;
    int failures = 0;
    int tests_run = 0;
    bme_exec dut (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .execBusy(execBusy));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic print_verdict();
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic waitRdy();
        int i;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (hreadyout !== 1'b1 && i < 40);
        if (hreadyout !== 1'b1) begin
            failures++;
            print_verdict();
        end
    endtask
    // address phase, then data phase
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
    endtask
    task automatic rc(input logic [11:0] a, input logic [7:0] e);
        ahb(1'b0, a, 32'h0);
        check(rd, {24'h0, e});
    endtask
    // count busy cycles until the instruction ends
    task automatic waitIdle(input int n);
        int c;
        c = 0;
        do begin
            @(posedge sys_clk);
            c++;
        end while (execBusy === 1'b1 && c < 20);
        check(32'(c - 1), 32'(n));
        if (execBusy === 1'b1) begin
            print_verdict();
        end
    endtask
    // start an instruction and count its busy cycles
    task automatic exec(input logic [23:0] ins, input int n);
        ahb(1'b1, 12'h400, {8'h00, ins});
        waitIdle(n);
    endtask
    // a low clock enable holds the running instruction
    task automatic tFreeze();
        ahb(1'b1, 12'h400, 32'h00_00_5F_77);
        ce <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check({31'h0, execBusy}, 32'h1);
        ce <= 1'b1;
        waitIdle(4);
        rc(12'h354, 8'hD0);
    endtask
    task automatic tReset();
        rc(12'h404, 8'hC0);
        rc(12'h354, 8'h00);
        ahb(1'b1, 12'h800, 32'hFF);
        rc(12'h800, 8'h00);
    endtask
    task automatic tCompl();
        ahb(1'b1, 12'h354, 32'hB0);
        ahb(1'b1, 12'h304, 32'h07);
        exec(24'h00_12_57, 4);
        rc(12'h304, 8'h05);
        rc(12'h354, 8'h90);
        ahb(1'b1, 12'h308, 32'h04);
        exec(24'h00_24_57, 4);
        rc(12'h308, 8'h00);
        rc(12'h354, 8'hD0);
    endtask
    task automatic tClrSet();
        exec(24'h00_10_77, 4);
        rc(12'h304, 8'h04);
        exec(24'h00_1F_77, 4);
        rc(12'h304, 8'h84);
        rc(12'h354, 8'hD0);
    endtask
    task automatic tBor();
        ahb(1'b1, 12'h004, 32'h03);
        exec(24'h01_12_07, 6);
        rc(12'h304, 8'h85);
        rc(12'h004, 8'h03);
        rc(12'h354, 8'h90);
        exec(24'h01_15_07, 6);
        rc(12'h004, 8'h07);
        rc(12'h304, 8'h85);
        ahb(1'b1, 12'h008, 32'hFD);
        exec(24'h02_22_07, 6);
        rc(12'h308, 8'h00);
        rc(12'h354, 8'hD0);
    endtask
    task automatic tBadStall();
        exec(24'h00_13_57, 0);
        rc(12'h408, 8'h02);
        rc(12'h304, 8'h85);
        ahb(1'b1, 12'h400, 32'h00_00_10_77);
        rc(12'h408, 8'h01);
        ahb(1'b1, 12'h404, 32'hD0);
        check({31'h0, execBusy}, 32'h0);
        rc(12'h304, 8'h84);
        exec(24'h00_5E_77, 4);
        rc(12'h354, 8'h50);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        tReset();
        tCompl();
        tClrSet();
        tBor();
        tBadStall();
        tFreeze();
        print_verdict();
    end
endmodule
